// ---- include/cal_regs_map.svh ----
// Notes on behaviour
// - Threshold upper word: sixteen bits, reset zero
// - Lower threshold byte in bits 15:8
// - Coefficient code: zero off, else 1/2^(n+1)
// - Phase delay: ten signed bits 15:6
// - Bypass bit 2 disables channel filter only
// - Input select bits 1:0, four sources
// - Offset upper word holds offset bits 23:8
// - Offset lower byte in bits 15:8
// - Gain upper word resets to 8000h
// - Gain lower byte in bits 15:8
`ifndef CAL_REGS_MAP_SVH
`define CAL_REGS_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CAL_IDX_THR_HIGH   6'h07
`define CAL_IDX_THR_LOW    6'h08
`define CAL_IDX_CHANNEL0_CONFIG    6'h09
`define CAL_IDX_OCAL_HIGH  6'h0a
`define CAL_IDX_OCAL_LOW   6'h0b
`define CAL_IDX_GCAL_HIGH  6'h0c
`define CAL_IDX_GCAL_LOW   6'h0d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CAL_LOW_BYTE_MSB   15
`define CAL_LOW_BYTE_LSB   8
`define CAL_COEF_MSB       3
`define CAL_COEF_LSB       0
`define CAL_PHASE_MSB      15
`define CAL_PHASE_LSB      6
`define CAL_BYPASS_BIT     2
`define CAL_SEL_MSB        1
`define CAL_SEL_LSB        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAL_RST_WORD       16'h0000
`define CAL_RST_BYTE       8'h00
`define CAL_RST_COEF       4'h0
`define CAL_RST_PHASE      10'h000
`define CAL_RST_GAIN_HIGH  16'h8000
`define CAL_COEF_OFF       4'h0

`endif

// ---- include/cal_regs_pkg.sv ----
package cal_regs_pkg;

    // Channel 0 input source selection
    typedef enum logic [1:0] {
        sel_external_pair,
        sel_inputs_shorted,
        sel_test_positive,
        sel_test_negative
    } input_select_t;

    typedef logic [15:0] reg_word_t;
    typedef logic [23:0] cal_value_t;

endpackage : cal_regs_pkg

// ---- design/channel_cfg_calibration_regs.sv ----
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "cal_regs_map.svh"

module channel_cfg_calibration_regs (
    input  wire logic                         ref_clk_in,
    input  wire logic                         arst_n_in,
    input  wire logic [7:0]                   address_in,
    input  wire logic                         read_in,
    input  wire logic                         write_in,
    input  wire logic [31:0]                  writedata_in,
    input  wire logic [3:0]                   byteenable_in,
    output logic [31:0]                       readdata_out,
    output logic                              waitrequest_out,
    output cal_regs_pkg::cal_value_t          detect_threshold_out,
    output logic [3:0]                        hp_filter_coefficient_out,
    output logic [4:0]                        hp_filter_shift_out,
    output logic                              channel0_hp_filter_active_out,
    output logic [9:0]                        channel0_phase_delay_out,
    output logic                              channel0_hp_filter_bypass_out,
    output cal_regs_pkg::input_select_t       channel0_input_select_out,
    output cal_regs_pkg::cal_value_t          channel0_offset_out,
    output cal_regs_pkg::cal_value_t          channel0_gain_out
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic                      ack_reg;
    logic                      wr_acc;
    logic                      rd_first;
    logic [5:0]                idx;
    logic                      hi_lane;
    logic                      lo_lane;
    logic [31:0]               rd_word;
    logic [31:0]               readdata_reg;

    cal_regs_pkg::reg_word_t   thr_high_reg;
    logic [7:0]                thr_low_reg;
    logic [3:0]                coef_reg;
    logic [9:0]                phase_reg;
    logic                      bypass_reg;
    cal_regs_pkg::input_select_t sel_reg;
    cal_regs_pkg::reg_word_t   ocal_high_reg;
    logic [7:0]                ocal_low_reg;
    cal_regs_pkg::reg_word_t   gcal_high_reg;
    logic [7:0]                gcal_low_reg;

    assign idx     = address_in[7:2];
    assign hi_lane = byteenable_in[1];
    assign lo_lane = byteenable_in[0];

    // One wait state: simple, and gives readdata a flop stage
    assign waitrequest_out = (read_in | write_in) & ~ack_reg;
    assign wr_acc          = write_in & ~waitrequest_out;
    assign rd_first        = read_in & ~ack_reg;

    // Ack toggles so every request sees exactly one stall cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read_in | write_in) & ~ack_reg;
        end
    end

    // ------------------------------------------------------------
    // Threshold and global filter coefficient
    // ------------------------------------------------------------
    // Upper threshold word, both lanes independent
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            thr_high_reg <= `CAL_RST_WORD;
        end else if (wr_acc && idx == `CAL_IDX_THR_HIGH) begin
            if (hi_lane) begin
                thr_high_reg[15:8] <= writedata_in[15:8];
            end
            if (lo_lane) begin
                thr_high_reg[7:0] <= writedata_in[7:0];
            end
        end
    end

    // Lower threshold byte and coefficient; bits 7:4 not stored
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            thr_low_reg <= `CAL_RST_BYTE;
            coef_reg    <= `CAL_RST_COEF;
        end else if (wr_acc && idx == `CAL_IDX_THR_LOW) begin
            if (hi_lane) begin
                thr_low_reg <= writedata_in[`CAL_LOW_BYTE_MSB:
                                            `CAL_LOW_BYTE_LSB];
            end
            if (lo_lane) begin
                coef_reg <= writedata_in[`CAL_COEF_MSB:`CAL_COEF_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel 0 configuration
    // ------------------------------------------------------------
    // Phase straddles both lanes, so each lane writes its part
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg  <= `CAL_RST_PHASE;
            bypass_reg <= 1'b0;
            sel_reg    <= cal_regs_pkg::sel_external_pair;
        end else if (wr_acc && idx == `CAL_IDX_CHANNEL0_CONFIG) begin
            if (hi_lane) begin
                phase_reg[9:2] <= writedata_in[15:8];
            end
            if (lo_lane) begin
                phase_reg[1:0] <= writedata_in[7:`CAL_PHASE_LSB];
                bypass_reg     <= writedata_in[`CAL_BYPASS_BIT];
                sel_reg        <= cal_regs_pkg::input_select_t'(
                    writedata_in[`CAL_SEL_MSB:`CAL_SEL_LSB]);
            end
        end
    end

    // ------------------------------------------------------------
    // Channel 0 offset and gain calibration
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ocal_high_reg <= `CAL_RST_WORD;
        end else if (wr_acc && idx == `CAL_IDX_OCAL_HIGH) begin
            if (hi_lane) begin
                ocal_high_reg[15:8] <= writedata_in[15:8];
            end
            if (lo_lane) begin
                ocal_high_reg[7:0] <= writedata_in[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ocal_low_reg <= `CAL_RST_BYTE;
        end else if (wr_acc && idx == `CAL_IDX_OCAL_LOW && hi_lane) begin
            ocal_low_reg <= writedata_in[`CAL_LOW_BYTE_MSB:
                                         `CAL_LOW_BYTE_LSB];
        end
    end

    // Gain defaults to unity so an untouched channel is not scaled
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gcal_high_reg <= `CAL_RST_GAIN_HIGH;
        end else if (wr_acc && idx == `CAL_IDX_GCAL_HIGH) begin
            if (hi_lane) begin
                gcal_high_reg[15:8] <= writedata_in[15:8];
            end
            if (lo_lane) begin
                gcal_high_reg[7:0] <= writedata_in[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gcal_low_reg <= `CAL_RST_BYTE;
        end else if (wr_acc && idx == `CAL_IDX_GCAL_LOW && hi_lane) begin
            gcal_low_reg <= writedata_in[`CAL_LOW_BYTE_MSB:
                                         `CAL_LOW_BYTE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Reserved bits and unmapped words read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (idx == `CAL_IDX_THR_HIGH) begin
            rd_word[15:0] = thr_high_reg;
        end else if (idx == `CAL_IDX_THR_LOW) begin
            rd_word[15:0] = {thr_low_reg, 4'h0, coef_reg};
        end else if (idx == `CAL_IDX_CHANNEL0_CONFIG) begin
            rd_word[15:0] = {phase_reg, 3'h0, bypass_reg, sel_reg};
        end else if (idx == `CAL_IDX_OCAL_HIGH) begin
            rd_word[15:0] = ocal_high_reg;
        end else if (idx == `CAL_IDX_OCAL_LOW) begin
            rd_word[15:0] = {ocal_low_reg, 8'h00};
        end else if (idx == `CAL_IDX_GCAL_HIGH) begin
            rd_word[15:0] = gcal_high_reg;
        end else if (idx == `CAL_IDX_GCAL_LOW) begin
            rd_word[15:0] = {gcal_low_reg, 8'h00};
        end
    end

    // Captured in the stall cycle, stands at the accepting edge
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            readdata_reg <= 32'h0000_0000;
        end else if (rd_first) begin
            readdata_reg <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Datapath outputs
    // ------------------------------------------------------------
    assign readdata_out              = readdata_reg;
    assign detect_threshold_out      = {thr_high_reg, thr_low_reg};
    assign hp_filter_coefficient_out = coef_reg;
    assign channel0_phase_delay_out  = phase_reg;
    assign channel0_hp_filter_bypass_out = bypass_reg;
    assign channel0_input_select_out = sel_reg;
    assign channel0_offset_out       = {ocal_high_reg, ocal_low_reg};
    assign channel0_gain_out         = {gcal_high_reg, gcal_low_reg};

    // Coefficient 1/2^(code+1): shift 2 for code 1, 16 for code 15
    assign hp_filter_shift_out = {1'b0, coef_reg} + 5'h01;
    // Filter runs only when enabled globally and not bypassed
    assign channel0_hp_filter_active_out =
        (coef_reg != `CAL_COEF_OFF) & ~bypass_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_wait_bound;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (read_in | write_in) |-> ##[0:1] !waitrequest_out;
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("request not answered within one wait state");

    property p_thr_upper;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_THR_HIGH && byteenable_in[1:0] == 2'h3)
        |=> detect_threshold_out[23:8] == $past(writedata_in[15:0]);
    endproperty
    a_thr_upper: assert property (p_thr_upper)
        else $error("threshold upper word not written");

    property p_thr_lower;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_THR_LOW && hi_lane)
        |=> detect_threshold_out[7:0] == $past(writedata_in[15:8]);
    endproperty
    a_thr_lower: assert property (p_thr_lower)
        else $error("threshold lower byte not written");

    property p_coef_shift;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (hp_filter_coefficient_out == 4'h0 |->
            !channel0_hp_filter_active_out) and
        (hp_filter_coefficient_out == 4'hf |->
            hp_filter_shift_out == 5'h10);
    endproperty
    a_coef_shift: assert property (p_coef_shift)
        else $error("filter coefficient decode wrong");

    property p_phase;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_CHANNEL0_CONFIG && byteenable_in[1:0] == 2'h3)
        |=> channel0_phase_delay_out == $past(writedata_in[15:6]);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase delay not written");

    property p_bypass;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        channel0_hp_filter_bypass_out |-> !channel0_hp_filter_active_out;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypassed channel filter still active");

    property p_select;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_CHANNEL0_CONFIG && lo_lane)
        |=> channel0_input_select_out == $past(writedata_in[1:0]);
    endproperty
    a_select: assert property (p_select)
        else $error("input select not written");

    property p_ocal_upper;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_OCAL_HIGH && byteenable_in[1:0] == 2'h3)
        |=> channel0_offset_out[23:8] == $past(writedata_in[15:0]);
    endproperty
    a_ocal_upper: assert property (p_ocal_upper)
        else $error("offset upper word not written");

    property p_ocal_lower;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_OCAL_LOW && hi_lane)
        |=> channel0_offset_out[7:0] == $past(writedata_in[15:8]);
    endproperty
    a_ocal_lower: assert property (p_ocal_lower)
        else $error("offset lower byte not written");

    property p_gcal_stable;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !(wr_acc && idx == `CAL_IDX_GCAL_HIGH)
        |=> channel0_gain_out[23:8] == $past(channel0_gain_out[23:8]);
    endproperty
    a_gcal_stable: assert property (p_gcal_stable)
        else $error("gain upper word changed without a write");

    property p_gcal_lower;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_acc && idx == `CAL_IDX_GCAL_LOW && hi_lane)
        |=> channel0_gain_out[7:0] == $past(writedata_in[15:8]);
    endproperty
    a_gcal_lower: assert property (p_gcal_lower)
        else $error("gain lower byte not written");

    property p_reserved_zero;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (read_in && !waitrequest_out) |->
            readdata_out[31:16] == 16'h0000 &&
            (idx != `CAL_IDX_THR_LOW || readdata_out[7:4] == 4'h0) &&
            (idx != `CAL_IDX_CHANNEL0_CONFIG || readdata_out[5:3] == 3'h0) &&
            (!(idx == `CAL_IDX_OCAL_LOW || idx == `CAL_IDX_GCAL_LOW) ||
             readdata_out[7:0] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

endmodule : channel_cfg_calibration_regs
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic                          ref_clk_in    = 1'b0;
    logic                          arst_n_in     = 1'b0;
    logic [7:0]                    address_in    = 8'h00;
    logic                          read_in       = 1'b0;
    logic                          write_in      = 1'b0;
    logic [31:0]                   writedata_in  = 32'h00000000;
    logic [3:0]                    byteenable_in = 4'hf;
    logic [31:0]                   readdata_out;
    logic                          waitrequest_out;
    cal_regs_pkg::cal_value_t      thr_seen;
    logic [3:0]                    coef_seen;
    logic [4:0]                    shift_seen;
    logic                          active_seen;
    logic [9:0]                    phase_seen;
    logic                          bypass_seen;
    cal_regs_pkg::input_select_t   sel_seen;
    cal_regs_pkg::cal_value_t      ofs_seen;
    cal_regs_pkg::cal_value_t      gain_seen;
    logic [15:0]                   shadow_reg [16];
    logic [15:0]                   rnd_reg       = 16'h005e;
    logic [31:0]                   rd;
    logic [5:0]                    pick;
    logic [5:0]                    unmapped_idx [4] = '{6'h00, 6'h06,
                                                        6'h0e, 6'h3f};
    int                            err_total     = 0;
    int                            n_tests       = 0;

    channel_cfg_calibration_regs i_channel_cfg_calibration_regs (
        .ref_clk_in                    (ref_clk_in),
        .arst_n_in                     (arst_n_in),
        .address_in                    (address_in),
        .read_in                       (read_in),
        .write_in                      (write_in),
        .writedata_in                  (writedata_in),
        .byteenable_in                 (byteenable_in),
        .readdata_out                  (readdata_out),
        .waitrequest_out               (waitrequest_out),
        .detect_threshold_out          (thr_seen),
        .hp_filter_coefficient_out     (coef_seen),
        .hp_filter_shift_out           (shift_seen),
        .channel0_hp_filter_active_out (active_seen),
        .channel0_phase_delay_out      (phase_seen),
        .channel0_hp_filter_bypass_out (bypass_seen),
        .channel0_input_select_out     (sel_seen),
        .channel0_offset_out           (ofs_seen),
        .channel0_gain_out             (gain_seen)
    );

    // 250 MHz clock
    always #2 ref_clk_in = ~ref_clk_in;

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    // Writable bits per word; zero marks an unmapped index
    function automatic logic [15:0] wmask(input logic [5:0] idx);
        case (idx)
            6'h07, 6'h0a, 6'h0c: return 16'hffff;
            6'h08:               return 16'hff0f;
            6'h09:               return 16'hffc7;
            6'h0b, 6'h0d:        return 16'hff00;
            default:             return 16'h0000;
        endcase
    endfunction : wmask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Values at reset: all clear except unity gain
    task automatic shadow_reset();
        foreach (shadow_reg[i]) shadow_reg[i] = 16'h0000;
        shadow_reg[12] = 16'h8000;
    endtask : shadow_reset

    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------------------------------
    // Avalon transfer: hold until waitrequest is low at a rising edge
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [15:0] data, input logic [1:0] be);
        int          n;
        logic [15:0] m;
        n = 0;
        m = wmask(idx) & {{8{be[1]}}, {8{be[0]}}};
        @(posedge ref_clk_in);
        address_in    <= {idx, 2'b00};
        writedata_in  <= {~data, data}; // Upper half must be ignored
        byteenable_in <= {2'b11, be};
        write_in      <= wr;
        read_in       <= ~wr;
        // Values read at a rising edge are those settled before it
        @(posedge ref_clk_in);
        while (waitrequest_out !== 1'b0 && n < 20) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            $display("Error at %0t: bus answer never came", $time);
            close_out();
        end
        rd       = readdata_out; // Taken at the accepting edge
        write_in <= 1'b0;
        read_in  <= 1'b0;
        if (wr) begin
            shadow_reg[idx[3:0]] = (shadow_reg[idx[3:0]] & ~m) | (data & m);
        end
    endtask : bus

    // Read one word and compare with the masked model
    task automatic read_chk(input logic [5:0] idx);
        logic [31:0] e;
        e = (wmask(idx) != 16'h0000) ? {16'h0000, shadow_reg[idx[3:0]]}
                                      : 32'h0000_0000;
        bus(1'b0, idx, 16'h0000, 2'b11);
        check(rd, e);
    endtask : read_chk

    // Every field output against the model, after the write lands
    task automatic check_outs();
        logic [15:0] c;
        @(negedge ref_clk_in);
        c = shadow_reg[9];
        check(thr_seen, {shadow_reg[7], shadow_reg[8][15:8]});
        check(coef_seen, shadow_reg[8][3:0]);
        check(shift_seen, {1'b0, shadow_reg[8][3:0]} + 5'h01);
        check(active_seen, shadow_reg[8][3:0] != 4'h0 && !c[2]);
        check(phase_seen, c[15:6]);
        check(bypass_seen, c[2]);
        check(sel_seen, c[1:0]);
        check(ofs_seen, {shadow_reg[10], shadow_reg[11][15:8]});
        check(gain_seen, {shadow_reg[12], shadow_reg[13][15:8]});
    endtask : check_outs

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        shadow_reset();
        repeat (8) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        // Reset values, outputs and readback
        check_outs();
        for (int i = 7; i <= 13; i++) read_chk(i[5:0]);
        $display("Test reset values done");
        // Random words and lanes; partial lanes split the phase field
        for (int i = 0; i < 60; i++) begin
            rnd_reg = lfsr(rnd_reg);
            pick    = 6'h07 + 6'(rnd_reg % 7);
            rnd_reg = lfsr(rnd_reg);
            bus(1'b1, pick, rnd_reg, (i % 4 == 0) ? 2'b11 : rnd_reg[9:8]);
            check_outs();
            read_chk(pick);
        end
        $display("Test random access done");
        // Every coefficient code and input source, reserved bits set
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, 6'h08, {8'h5a, 4'hf, 4'(k)}, 2'b11);
            bus(1'b1, 6'h09, {10'(k * 37), 3'h7, k[0], k[2:1]}, 2'b11);
            check_outs();
            read_chk(6'h08);
            read_chk(6'h09);
        end
        $display("Test coefficient and source codes done");
        // Unmapped places: writes lost, reads zero
        for (int j = 0; j < 4; j++) begin
            bus(1'b1, unmapped_idx[j], 16'hffff, 2'b11);
            read_chk(unmapped_idx[j]);
        end
        check_outs();
        $display("Test unmapped access done");
        // Reset in mid-run brings back the defaults
        @(posedge ref_clk_in);
        arst_n_in <= 1'b0;
        shadow_reset();
        check_outs();
        repeat (2) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        for (int i = 7; i <= 13; i++) read_chk(i[5:0]);
        $display("Test second reset done");
        close_out();
    end
endmodule : testbench

`default_nettype wire
